// ### pkg/supply_detector_defs.vh
// constants for the supply detector control block
`ifndef SUPPLY_DETECTOR_DEFS_VH
`define SUPPLY_DETECTOR_DEFS_VH
// ---------------------------------------------
// register byte offsets
// ---------------------------------------------
`define SD_CTRL_OFS      12'h000
`define SD_FLAG_OFS      12'h004
`define SD_IRQEN_OFS     12'h008
// ---------------------------------------------
// control field positions
// ---------------------------------------------
`define SD_SRC_BIT       15
`define SD_SC_HI         14
`define SD_SC_LO         13
`define SD_LVL_HI        12
`define SD_LVL_LO        8
`define SD_RE_HI         7
`define SD_RE_LO         4
`define SD_RISE_BIT      3
`define SD_MD_HI         2
`define SD_MD_LO         1
`define SD_EN_BIT        0
`define SD_RESULT_BIT    8
`define SD_FLAG_BIT      0
`define SD_IRQEN_BIT     0
// ---------------------------------------------
// reset values and codes
// ---------------------------------------------
`define SD_LVL_RST       5'h1e
`define SD_RE_KEY        4'ha
`define SD_MD_CONT       2'h0
// ---------------------------------------------
// timing: detector clock and sample intervals
// ---------------------------------------------
`define SD_CORE_MHZ      250
`define SD_DET_KHZ       32
`define SD_DET_DIV       ((`SD_CORE_MHZ * 1000) / `SD_DET_KHZ)
`define SD_INT1          10'd128
`define SD_INT2          10'd256
`define SD_INT3          10'd512
`define SD_STOP_TICKS    2'd2
`endif

// ### verilog/supply_detector_ctrl.v
// supply detector control, status and bus slave
// Summary of operation
// - bit 15 picks external sense or main
// - intermittent needs 1, 2, 4 or 8 hits
// - continuous mode ignores successive count
// - five-bit threshold drives comparator level
// - reset only when field equals 0xa
// - bit 3 picks rise or drop
// - cycle codes: continuous, 128, 256, 512
// - disable resets logic, enable reads late
// - changing sc, re, cycle reinitialises
// - result bit shows drop or rise condition
// - event flag, write one clears
// - clearing flag while enabled reinitialises
// - irq enable gates detection interrupts
// - reset mode issues reset, no interrupt
// - irq high only when flag and enable
// - flag sets on result or run count
// - after reset: continuous, some bits cleared
// - rise mode never issues a reset
`timescale 1ns/1ps
`include "supply_detector_defs.vh"

module supply_detector_ctrl #(
    parameter DET_DIV = `SD_DET_DIV
) (
    input  wire        core_clk,
    input  wire        reset_n,
    input  wire        hsel,
    input  wire [11:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    input  wire        compBelow,
    output wire        compEnable,
    output wire        sourceSelect,
    output wire [4:0]  thresholdLevel,
    output wire        irqRequest,
    output reg         resetRequest
);

// ---------------------------------------------
// control and status registers
// ---------------------------------------------
reg        srcSel_q;      // external sense when set
reg [1:0]  scSel_q;       // successive count code
reg [4:0]  level_q;       // threshold level code
reg [3:0]  resetKey_q;    // reset-on-drop field
reg        riseSel_q;     // rise when set
reg [1:0]  cycleSel_q;    // detect cycle code
reg        enable_q;      // detector enable as read
reg        result_q;      // latest detect result
reg        flag_q;        // sticky event flag
reg        irqEn_q;       // interrupt enable
reg [1:0]  stopCnt_q;     // disable sequence counter
reg        stopping_q;    // internal reset running

// ---------------------------------------------
// bus address phase capture
// ---------------------------------------------
reg        wrPend_q;      // write data phase pending
reg [11:0] wrAddr_q;      // address of that write

// ---------------------------------------------
// detector timing and detection state
// ---------------------------------------------
reg [31:0] divCnt_q;      // core cycles per detector tick
reg [9:0]  intCnt_q;      // detector ticks per sample
reg [3:0]  runCnt_q;      // consecutive hits
reg        belowS1_q;     // synchroniser stage one
reg        belowS2_q;     // synchroniser stage two
reg [1:0]  warm_q;        // comparator power, two cycles of history

wire detTick = (divCnt_q == DET_DIV - 1);
wire running = enable_q && !stopping_q;
wire contMode = (cycleSel_q == `SD_MD_CONT);
wire resetMode = (resetKey_q == `SD_RE_KEY) && !riseSel_q;

// picks the sample interval from the cycle code
function [9:0] interval;
    input [1:0] code;
    begin
        if (code == 2'h1) begin
            interval = `SD_INT1;
        end else if (code == 2'h2) begin
            interval = `SD_INT2;
        end else begin
            interval = `SD_INT3;
        end
    end
endfunction

// number of unbroken hits the count code asks for
function [3:0] needHits;
    input [1:0] code;
    begin
        needHits = 4'h1 << code;
    end
endfunction

// ---------------------------------------------
// bus decode
// ---------------------------------------------
wire addrPhase = hsel && htrans[1] && hready;
wire wrCtrl  = wrPend_q && (wrAddr_q == `SD_CTRL_OFS);
wire wrFlag  = wrPend_q && (wrAddr_q == `SD_FLAG_OFS);
wire wrIrqEn = wrPend_q && (wrAddr_q == `SD_IRQEN_OFS);
wire [15:0] wd = hwdata[15:0];

// zero wait states, always OKAY
assign hreadyout = 1'b1;
assign hresp     = 1'b0;

// a write that changes sc, re or cycle while running
wire cfgChange = wrCtrl && running &&
                 ((wd[`SD_SC_HI:`SD_SC_LO] != scSel_q) ||
                  (wd[`SD_RE_HI:`SD_RE_LO] != resetKey_q) ||
                  (wd[`SD_MD_HI:`SD_MD_LO] != cycleSel_q));
wire flagClr = wrFlag && wd[`SD_FLAG_BIT];
// reinit clears the interval and hit counters; the divider, flag and settings stay
wire reinit = cfgChange || (flagClr && running);

// ---------------------------------------------
// comparator pins
// ---------------------------------------------
assign sourceSelect   = srcSel_q;
assign thresholdLevel = level_q;
// intermittent mode powers the comparator for one tick before sampling
assign compEnable = running && (contMode || intCnt_q == 10'd0);
assign irqRequest = flag_q && irqEn_q;

// ---------------------------------------------
// sample decision
// ---------------------------------------------
// polarity of the synchronised comparator output
wire hit = riseSel_q ? !belowS2_q : belowS2_q;
// the sample is taken at the end of the comparator-on tick only if the comparator
// was also on two cycles earlier, so stale synchroniser data never counts
wire sample = running && detTick && compEnable && warm_q[1];
wire [3:0] runNext = runCnt_q + 4'h1;
// continuous: rising result; intermittent: run reached
wire event_ = sample && (contMode ? (hit && !result_q)
                                  : (hit && runNext >= needHits(scSel_q)));
wire fireReset = event_ && resetMode;
wire fireIrq   = event_ && !resetMode;

// ---------------------------------------------
// comparator synchroniser
// ---------------------------------------------
// comparator output is asynchronous to core_clk
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        belowS1_q <= 1'b0;
        belowS2_q <= 1'b0;
        warm_q    <= 2'h0;
    end else begin
        belowS1_q <= compBelow;
        belowS2_q <= belowS1_q;
        warm_q    <= {warm_q[0], compEnable};
    end
end

// ---------------------------------------------
// detector clock divider and interval counter
// ---------------------------------------------
// the detector clock is a tick from a divider, not a second domain
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        divCnt_q <= 32'h0;
        intCnt_q <= 10'h0;
    end else begin
        divCnt_q <= detTick ? 32'h0 : divCnt_q + 32'h1;
        if (!running || reinit || contMode || fireReset) begin
            intCnt_q <= 10'h0;
        end else if (detTick) begin
            // wrap after the selected interval
            if (intCnt_q == interval(cycleSel_q) - 10'd1) begin
                intCnt_q <= 10'h0;
            end else begin
                intCnt_q <= intCnt_q + 10'h1;
            end
        end
    end
end

// ---------------------------------------------
// consecutive hit counter and result latch
// ---------------------------------------------
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        runCnt_q <= 4'h0;
        result_q <= 1'b0;
    end else if (!running || reinit) begin
        runCnt_q <= 4'h0;
        result_q <= running ? result_q : 1'b0;
    end else if (sample) begin
        result_q <= hit;
        if (!hit || event_ || contMode) begin
            runCnt_q <= 4'h0;
        end else begin
            runCnt_q <= runNext;
        end
    end
end

// ---------------------------------------------
// reset request
// ---------------------------------------------
// held until the result returns to 0, then released
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        resetRequest <= 1'b0;
    end else if (!running) begin
        resetRequest <= 1'b0;
    end else if (fireReset) begin
        resetRequest <= 1'b1;
    end else if (resetRequest && sample && !hit) begin
        resetRequest <= 1'b0;
    end
end

// ---------------------------------------------
// event flag
// ---------------------------------------------
// a new event in the clear cycle wins over the clear
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        flag_q <= 1'b0;
    end else if (fireIrq) begin
        flag_q <= 1'b1;
    end else if (flagClr) begin
        flag_q <= 1'b0;
    end
end

// ---------------------------------------------
// enable and internal stop sequence
// ---------------------------------------------
// enable keeps reading 1 until the stop sequence ends
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        enable_q   <= 1'b0;
        stopping_q <= 1'b0;
        stopCnt_q  <= 2'h0;
    end else if (stopping_q) begin
        if (detTick) begin
            if (stopCnt_q == `SD_STOP_TICKS - 2'd1) begin
                enable_q   <= 1'b0;
                stopping_q <= 1'b0;
                stopCnt_q  <= 2'h0;
            end else begin
                stopCnt_q <= stopCnt_q + 2'h1;
            end
        end
    end else if (wrCtrl) begin
        if (enable_q && !wd[`SD_EN_BIT]) begin
            stopping_q <= 1'b1;
        end else if (!enable_q && wd[`SD_EN_BIT]) begin
            // a 1 written mid-stop is dropped; software must wait
            enable_q <= 1'b1;
        end
    end
end

// ---------------------------------------------
// configuration registers
// ---------------------------------------------
// reset issue forces continuous drop mode, clears sc and irq enable
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        srcSel_q   <= 1'b0;
        scSel_q    <= 2'h0;
        level_q    <= `SD_LVL_RST;
        resetKey_q <= 4'h0;
        riseSel_q  <= 1'b0;
        cycleSel_q <= `SD_MD_CONT;
        irqEn_q    <= 1'b0;
    end else begin
        // a write in the reset cycle still lands; the reset forcing wins below
        if (wrCtrl) begin
            srcSel_q   <= wd[`SD_SRC_BIT];
            scSel_q    <= wd[`SD_SC_HI:`SD_SC_LO];
            level_q    <= wd[`SD_LVL_HI:`SD_LVL_LO];
            resetKey_q <= wd[`SD_RE_HI:`SD_RE_LO];
            riseSel_q  <= wd[`SD_RISE_BIT];
            cycleSel_q <= wd[`SD_MD_HI:`SD_MD_LO];
        end
        if (wrIrqEn) begin
            irqEn_q <= wd[`SD_IRQEN_BIT];
        end
        if (fireReset) begin
            scSel_q    <= 2'h0;
            riseSel_q  <= 1'b0;
            cycleSel_q <= `SD_MD_CONT;
            irqEn_q    <= 1'b0;
        end
    end
end

// ---------------------------------------------
// bus slave: address capture and read data
// ---------------------------------------------
// read data is registered in the address phase, so it stands in the data phase
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        wrPend_q <= 1'b0;
        wrAddr_q <= 12'h0;
        hrdata   <= 32'h0;
    end else begin
        wrPend_q <= addrPhase && hwrite;
        wrAddr_q <= haddr;
        hrdata   <= 32'h0;
        if (addrPhase && !hwrite) begin
            if (haddr == `SD_CTRL_OFS) begin
                hrdata <= {16'h0, srcSel_q, scSel_q, level_q, resetKey_q,
                           riseSel_q, cycleSel_q, enable_q};
            end else if (haddr == `SD_FLAG_OFS) begin
                hrdata <= {23'h0, result_q, 7'h0, flag_q};
            end else if (haddr == `SD_IRQEN_OFS) begin
                hrdata <= {31'h0, irqEn_q};
            end
        end
    end
end

endmodule

// ### bench/supply_partner.sv
// comparator model facing the detector block
`timescale 1ns/1ps
module supply_partner (
    input  wire       core_clk,
    input  wire       compEnable,
    input  wire       sourceSelect,
    input  wire [4:0] thresholdLevel,
    input  wire [4:0] mainLevel,
    input  wire [4:0] extLevel,
    output wire       compBelow
);
    wire [4:0] lvl = sourceSelect ? extLevel : mainLevel; // routed supply
    reg        wander_q = 1'b0; // unpowered output means nothing
    // --------
    // powered down: output flips every cycle
    // --------
    always @(posedge core_clk) begin
        wander_q <= ~wander_q;
    end
    assign compBelow = compEnable ? (lvl < thresholdLevel) : wander_q;
endmodule

// ### bench/supply_detector_ctrl_props.sv
// assertion checker for the supply detector control block
`timescale 1ns/1ps
`include "supply_detector_defs.vh"
module supply_detector_ctrl_props (
    input wire        core_clk,
    input wire        reset_n,
    input wire        hsel,
    input wire [11:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    input wire        compBelow,
    input wire        sourceSelect,
    input wire [4:0]  thresholdLevel,
    input wire        irqRequest,
    input wire        resetRequest
);
    // --------
    // data phase tracking
    // --------
    wire      take = hsel & htrans[1] & hready; // address phase taken
    reg       wrCtrl_q; // ctrl write in data phase
    reg       wrIrq_q;  // irq enable write in data phase
    reg       rd_q;     // read in data phase
    reg       rise_q;   // rise select as written
    reg [3:0] key_q;    // reset key as written
    // follow the bus so outputs tie back to their cause
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wrCtrl_q <= 1'b0;
            wrIrq_q <= 1'b0;
            rd_q <= 1'b0;
            rise_q <= 1'b0;
            key_q <= 4'h0;
        end else begin
            wrCtrl_q <= take & hwrite & (haddr == `SD_CTRL_OFS);
            wrIrq_q <= take & hwrite & (haddr == `SD_IRQEN_OFS);
            rd_q <= take & ~hwrite;
            if (wrCtrl_q) begin
                rise_q <= hwdata[3];
                key_q <= hwdata[7:4];
            end
        end
    end
    // --------
    // properties
    // --------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not zero-wait okay");
    a_src_follow: assert property (wrCtrl_q |=> sourceSelect == $past(hwdata[15]))
        else $error("source select does not follow write");
    a_level_follow: assert property (wrCtrl_q |=> thresholdLevel == $past(hwdata[12:8]))
        else $error("threshold does not follow write");
    a_rdata_idle: assert property (!rd_q |-> hrdata == 32'h0)
        else $error("read data outside read phase");
    a_irq_gate: assert property (wrIrq_q && !hwdata[0] |=> !irqRequest)
        else $error("interrupt with enable cleared");
    a_rise_no_rst: assert property ($rose(resetRequest) |-> key_q == 4'ha && !rise_q)
        else $error("reset without key or in rise mode");
    a_fire_no_irq: assert property ($rose(resetRequest) |=> !irqRequest)
        else $error("interrupt beside reset");
    a_rst_release: assert property ((!compBelow) [*8] |=> !resetRequest)
        else $error("reset held without detection");
    c_reset_fire: cover property ($rose(resetRequest));
    c_irq_raise: cover property ($rose(irqRequest));
    c_ctrl_write: cover property (wrCtrl_q);
endmodule
bind supply_detector_ctrl supply_detector_ctrl_props chk_u (
    .core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .compBelow(compBelow),
    .sourceSelect(sourceSelect), .thresholdLevel(thresholdLevel),
    .irqRequest(irqRequest), .resetRequest(resetRequest));

// ### bench/supply_detector_ctrl_tb.sv
// self-checking testbench for the supply detector control block
`timescale 1ns/1ps
`include "supply_detector_defs.vh"
module supply_detector_ctrl_tb;
    // --------
    // signals
    // --------
    localparam DIV = 4; // short detector tick keeps the run brief
    reg         core_clk = 1'b0;
    reg         reset_n = 1'b0;
    reg         hsel = 1'b0;
    reg  [11:0] haddr = 12'h000;
    reg  [1:0]  htrans = 2'h0;
    reg         hwrite = 1'b0;
    reg  [2:0]  hsize = 3'h2;
    reg  [31:0] hwdata = 32'h0;
    reg  [4:0]  mainLevel = 5'h1f; // main supply level
    reg  [4:0]  extLevel = 5'h1f;  // external sense level
    wire [31:0] hrdata;
    wire        hreadyout, hresp, compBelow, compEnable, sourceSelect;
    wire [4:0]  thresholdLevel;
    wire        irqRequest, resetRequest;
    integer     errors = 0;
    integer     tests_run = 0;
    integer     i, n, p, c;    // loop, samples, period, waited
    reg  [31:0] rd, cfg;       // read data, ctrl word
    reg  [4:0]  lvl;           // threshold code
    reg         src;           // routed source
    always #2 core_clk = ~core_clk;
    supply_detector_ctrl #(.DET_DIV(DIV)) dut_u (
        .core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .compBelow(compBelow), .compEnable(compEnable), .sourceSelect(sourceSelect),
        .thresholdLevel(thresholdLevel), .irqRequest(irqRequest),
        .resetRequest(resetRequest));
    supply_partner model_u (
        .core_clk(core_clk), .compEnable(compEnable), .sourceSelect(sourceSelect),
        .thresholdLevel(thresholdLevel), .mainLevel(mainLevel), .extLevel(extLevel),
        .compBelow(compBelow));
    // --------
    // helpers
    // --------
    function [31:0] ctl(input s, input [1:0] sc, input [4:0] l, input [3:0] k,
                        input r, input [1:0] md, input en);
        ctl = {16'h0, s, sc, l, k, r, md, en};
    endfunction
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // one single transfer; ports settle before return
    task xfer(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge core_clk);
            hsel <= 1'b1;
            haddr <= a;
            htrans <= 2'h2;
            hwrite <= w;
            @(posedge core_clk);
            while (hreadyout !== 1'b1) @(posedge core_clk);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            @(posedge core_clk);
            while (hreadyout !== 1'b1) @(posedge core_clk);
            rd = hrdata;
            #1;
        end
    endtask
    task setLv(input [4:0] m, input [4:0] e);
        begin
            @(posedge core_clk);
            mainLevel <= m;
            extLevel <= e;
        end
    endtask
    // bounded wait for an interrupt or a reset request
    task waitFor(input rst, input integer lim);
        begin
            c = 0;
            while ((rst ? resetRequest : irqRequest) !== 1'b1 && c < lim) begin
                @(posedge core_clk);
                #1;
                c = c + 1;
            end
        end
    endtask
    // disable, then poll until enable reads back low
    task stop;
        begin
            xfer(1, `SD_CTRL_OFS, cfg & 32'hfffe);
            xfer(0, `SD_CTRL_OFS, 0);
            chk(rd[0], 1);
            c = 0;
            rd = 1;
            while (rd[0] !== 1'b0 && c < 30) begin
                xfer(0, `SD_CTRL_OFS, 0);
                c = c + 1;
            end
            chk(rd, cfg & 32'hfffe);
        end
    endtask
    task end_of_test;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, errors);
            if (errors == 0 && tests_run > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial begin
        repeat (90000) @(posedge core_clk);
        errors = errors + 1;
        end_of_test;
    end
    // --------
    // scenarios
    // --------
    initial begin
        cfg = $urandom(89414);
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        xfer(0, `SD_CTRL_OFS, 0);
        chk(rd, 32'h1e00);
        xfer(0, 12'h00c, 0);
        chk(rd, 0);
        for (i = 0; i < 6; i = i + 1) begin
            cfg = $urandom & 32'hfffffffe; // random fields, detector off
            xfer(1, `SD_CTRL_OFS, cfg);
            xfer(0, `SD_CTRL_OFS, 0);
            chk(rd, cfg & 32'hffff);
            chk({sourceSelect, thresholdLevel}, {cfg[15], cfg[12:8]});
        end
        $display("done registers");
        // continuous drop: only the routed supply is low
        lvl = 5'd4 + $urandom % 27;
        src = $urandom;
        setLv(src ? lvl : lvl - 5'd1, src ? lvl - 5'd1 : lvl);
        xfer(1, `SD_FLAG_OFS, 1);
        xfer(1, `SD_IRQEN_OFS, 1);
        cfg = ctl(src, $urandom, lvl, 4'h0, 1'b0, 2'h0, 1'b1);
        xfer(1, `SD_CTRL_OFS, cfg);
        waitFor(0, 40);
        chk(irqRequest, 1);
        xfer(1, `SD_FLAG_OFS, 0);
        xfer(0, `SD_FLAG_OFS, 0);
        chk(rd, 32'h101);
        xfer(1, `SD_IRQEN_OFS, 0);
        chk(irqRequest, 0);
        stop;
        xfer(0, `SD_FLAG_OFS, 0);
        chk(rd & 1, 1);
        xfer(1, `SD_FLAG_OFS, 1);
        xfer(0, `SD_FLAG_OFS, 0);
        chk(rd & 1, 0);
        $display("done continuous");
        // rise mode with the reset key still interrupts only
        setLv(lvl, 5'h00);
        xfer(1, `SD_IRQEN_OFS, 1);
        cfg = ctl(0, 0, lvl, `SD_RE_KEY, 1, 0, 1);
        xfer(1, `SD_CTRL_OFS, cfg);
        waitFor(0, 40);
        chk({irqRequest, resetRequest}, 2'b10);
        stop;
        xfer(1, `SD_FLAG_OFS, 1);
        $display("done rise");
        // intermittent: every count code, cycle code rotates
        setLv(lvl - 5'd1, 5'h1f);
        for (i = 0; i < 4; i = i + 1) begin
            n = 1 << i;
            p = (64 << (i % 3 + 1)) * DIV;
            cfg = ctl(0, i, lvl, 0, 0, i % 3 + 1, 1);
            xfer(1, `SD_CTRL_OFS, cfg);
            repeat (2) begin
                waitFor(0, n * p + p);
                chk(c >= (n - 1) * p && c <= n * p + 40, 1);
                xfer(1, `SD_FLAG_OFS, 1);
            end
            stop;
        end
        $display("done intermittent");
        // drop with the reset key: reset, no interrupt, fields fall back
        cfg = ctl(0, 1, lvl, `SD_RE_KEY, 0, 2, 1);
        xfer(1, `SD_CTRL_OFS, cfg);
        waitFor(1, 3 * 1024 * DIV);
        chk({resetRequest, irqRequest}, 2'b10);
        cfg = ctl(0, 0, lvl, `SD_RE_KEY, 0, 0, 1);
        xfer(0, `SD_CTRL_OFS, 0);
        chk(rd, cfg);
        xfer(0, `SD_IRQEN_OFS, 0);
        chk(rd, 0);
        xfer(0, `SD_FLAG_OFS, 0);
        chk(rd, 32'h100);
        setLv(5'h1f, 5'h1f);
        repeat (4 * DIV) @(posedge core_clk);
        #1 chk(resetRequest, 0);
        stop;
        $display("done reset mode");
        end_of_test;
    end
endmodule
